/* File: ssp_pkg.sv */
// ssp_pkg: constants of the serial-load synthesizer control block
// assumes: included by the top and the bench, nothing imported
package ssp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // serial word and latch select
    localparam int WORD_W = 24;
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_FBK = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int REF_CNT_LSB = 2;
    localparam int REF_CNT_W = 14;
    localparam int LDP_BIT = 20;
    localparam int SWALLOW_LSB = 2;
    localparam int SWALLOW_W = 6;
    localparam int MAIN_LSB = 8;
    localparam int MAIN_W = 13;
    localparam int CNT_RST_BIT = 2;
    localparam int PWRDN_BIT = 3;
    localparam int MUX_LSB = 4;
    localparam int MUX_W = 3;
    localparam int CP_POL_BIT = 7;
    localparam int CP_TRI_BIT = 8;
    localparam int PRESC_LSB = 22;
    localparam int PRESC_W = 2;

    ////////////////////////////////////////////////////////////////////////
    // observation mux selections
    localparam logic [2:0] MUX_LOCK = 3'h1;
    localparam logic [2:0] MUX_FBK_DIV = 3'h2;
    localparam logic [2:0] MUX_REF_DIV = 3'h4;

    // lock needs this many coincident phase cycles (precision 0 / 1)
    localparam logic [2:0] LOCK_CNT_LO = 3'h3;
    localparam logic [2:0] LOCK_CNT_HI = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_REF = 8'h04;
    localparam logic [7:0] A_FBK = 8'h08;
    localparam logic [7:0] A_FUNC = 8'h0C;
    localparam logic [7:0] A_INIT = 8'h10;
    localparam logic [7:0] A_SHIFT = 8'h14;
    localparam logic [7:0] A_CTRL = 8'h18;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [23:0] LATCH_RST = 24'h000000;

endpackage

/* File: ssp_prescaler.sv */
// ssp_prescaler: dual-modulus divider on sampled rf edges
// assumes: rf_edge is a one-cycle pulse in the aclk domain
`timescale 1ns/100ps
module ssp_prescaler
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic rf_edge,
    input wire logic [1:0] presc_sel,
    input wire logic modulus_hi,
    output logic out_pulse
);

    logic [2:0] core_q;
    logic [4:0] outer_q;
    logic [4:0] span;
    logic outer_last;
    logic core_last;

    // 4/5 core repeated 2,4,8,16 times gives P = 8..64, P+1 by one 5
    assign span = 5'h02 << presc_sel;
    assign outer_last = outer_q == 5'(span - 5'h01);
    assign core_last = (modulus_hi && outer_last) ? core_q == 3'h4
                                                  : core_q == 3'h3;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear)
        begin
            core_q <= 3'h0;
            outer_q <= 5'h00;
            out_pulse <= 1'b0;
        end
        else
        begin
            out_pulse <= rf_edge && core_last && outer_last;
            if (rf_edge)
            begin
                core_q <= core_last ? 3'h0 : 3'(core_q + 3'h1);
                if (core_last)
                    outer_q <= outer_last ? 5'h00 : 5'(outer_q + 5'h01);
            end
        end
    end

endmodule // ssp_prescaler

/* File: ssp_top.sv */
// ssp_top: three-wire load front end, feedback and reference dividers,
// observation mux and power gating, with an AXI4-Lite register window
// assumes: pins are asynchronous to aclk and change slower than 3 aclk
`timescale 1ns/100ps

// Overview of operation
// - shift serial data on each serial clock rise
// - word arrives MSB first, last two bits select
// - strobe rise copies word into one latch, init select also into function
// - chip enable low: powered down, pump tristated
// - chip enable high powers up unless bit or ctrl register holds
// - mux shows lock, divided rf or divided reference
// - power down opens reference path, closes idle switch
// - prescaler modulus 8/9, 16/17, 32/33, 64/65
// - feedback ratio main times modulus plus swallow
// - larger moduli derived from 4/5 core
// - select 00 ref, 01 feedback, 10 function, 11 init
module ssp_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic reference_input,
    input wire logic rf_feedback_input,
    output logic charge_pump_output,
    output logic charge_pump_output_oe_n,
    output logic observe_mux_output,
    output logic ref_path_switch_a,
    output logic ref_path_switch_b,
    output logic ref_idle_switch,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int NPIN = 6;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a level counts once stages two and three agree
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_q;
    logic [NPIN-1:0] s2_q;
    logic [NPIN-1:0] s3_q;
    logic [NPIN-1:0] lvl_q;
    logic [NPIN-1:0] rise;

    assign pin_raw = {rf_feedback_input, reference_input, chip_enable,
                      load_strobe, serial_data, serial_clk};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    lvl_q[gi] <= 1'b0;
                end
                else
                begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi])
                        lvl_q[gi] <= s3_q[gi];
                end
            end
            assign rise[gi] = s2_q[gi] && s3_q[gi] && !lvl_q[gi];
        end
    endgenerate

    logic sclk_rise;
    logic strobe_rise;
    logic ce_lvl;
    logic ref_rise;
    logic rf_rise;
    assign sclk_rise = rise[0];
    assign strobe_rise = rise[2];
    assign ce_lvl = lvl_q[3];
    assign ref_rise = rise[4];
    assign rf_rise = rise[5];

    ////////////////////////////////////////////////////////////////////////
    // shift register and latches
    logic [23:0] shift_q;
    logic [23:0] ref_latch_q;
    logic [23:0] fbk_latch_q;
    logic [23:0] func_latch_q;
    logic [23:0] init_latch_q;
    logic [1:0] sel;
    assign sel = shift_q[ssp_pkg::SEL_W-1:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            shift_q <= ssp_pkg::LATCH_RST;
        else if (sclk_rise)
            shift_q <= {shift_q[ssp_pkg::WORD_W-2:0], lvl_q[1]};
    end

    // only reset and a strobe rise touch a latch
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ref_latch_q <= ssp_pkg::LATCH_RST;
            fbk_latch_q <= ssp_pkg::LATCH_RST;
            func_latch_q <= ssp_pkg::LATCH_RST;
            init_latch_q <= ssp_pkg::LATCH_RST;
        end
        else if (strobe_rise)
        begin
            case (sel)
                ssp_pkg::SEL_REF: ref_latch_q <= shift_q;
                ssp_pkg::SEL_FBK: fbk_latch_q <= shift_q;
                ssp_pkg::SEL_FUNC: func_latch_q <= shift_q;
                ssp_pkg::SEL_INIT:
                begin
                    init_latch_q <= shift_q;
                    func_latch_q <= shift_q;
                end
                default: ref_latch_q <= ref_latch_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fields and power state
    logic [13:0] ref_div;
    logic [5:0] swallow;
    logic [12:0] main_div;
    logic [1:0] presc_sel;
    logic [2:0] mux_sel;
    logic pd_bit;
    logic cnt_reset;
    logic ctrl_pd_q;
    logic powered;
    logic hold;

    assign ref_div = ref_latch_q[ssp_pkg::REF_CNT_LSB +: ssp_pkg::REF_CNT_W];
    assign swallow = fbk_latch_q[ssp_pkg::SWALLOW_LSB +: ssp_pkg::SWALLOW_W];
    assign main_div = fbk_latch_q[ssp_pkg::MAIN_LSB +: ssp_pkg::MAIN_W];
    assign presc_sel = func_latch_q[ssp_pkg::PRESC_LSB +: ssp_pkg::PRESC_W];
    assign mux_sel = func_latch_q[ssp_pkg::MUX_LSB +: ssp_pkg::MUX_W];
    assign pd_bit = func_latch_q[ssp_pkg::PWRDN_BIT];
    assign cnt_reset = func_latch_q[ssp_pkg::CNT_RST_BIT];
    assign powered = ce_lvl && !pd_bit && !ctrl_pd_q;
    assign hold = !powered || cnt_reset;

    ////////////////////////////////////////////////////////////////////////
    // feedback divider: A cycles of P+1, then B-A cycles of P
    logic [5:0] a_q;
    logic [12:0] b_q;
    logic presc_pulse;
    logic fbk_pulse_q;
    logic fbk_wrap;

    ssp_prescaler u_presc
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(hold),
        .rf_edge(rf_rise),
        .presc_sel(presc_sel),
        .modulus_hi(a_q != 6'h00),
        .out_pulse(presc_pulse)
    );

    assign fbk_wrap = presc_pulse && b_q <= 13'h0001;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
        begin
            a_q <= swallow;
            b_q <= main_div;
            fbk_pulse_q <= 1'b0;
        end
        else
        begin
            fbk_pulse_q <= fbk_wrap;
            if (fbk_wrap)
            begin
                a_q <= swallow;
                b_q <= main_div;
            end
            else if (presc_pulse)
            begin
                b_q <= 13'(b_q - 13'h0001);
                if (a_q != 6'h00)
                    a_q <= 6'(a_q - 6'h01);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference divider
    logic [13:0] r_q;
    logic ref_pulse_q;
    logic ref_wrap;
    assign ref_wrap = ref_rise && r_q <= 14'h0001;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
        begin
            r_q <= ref_div;
            ref_pulse_q <= 1'b0;
        end
        else
        begin
            ref_pulse_q <= ref_wrap;
            if (ref_wrap)
                r_q <= ref_div;
            else if (ref_rise)
                r_q <= 14'(r_q - 14'h0001);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase detector, lock detect
    logic up_q;
    logic dn_q;
    logic [2:0] good_q;
    logic lock_q;
    logic [2:0] lock_need;
    logic coincide;
    logic miss;

    assign lock_need = ref_latch_q[ssp_pkg::LDP_BIT] ? ssp_pkg::LOCK_CNT_HI
                                                    : ssp_pkg::LOCK_CNT_LO;
    assign coincide = ref_pulse_q && fbk_pulse_q;
    assign miss = ref_pulse_q != fbk_pulse_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
        begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            good_q <= 3'h0;
            lock_q <= 1'b0;
        end
        else
        begin
            up_q <= (up_q || ref_pulse_q) && !(dn_q || fbk_pulse_q);
            dn_q <= (dn_q || fbk_pulse_q) && !(up_q || ref_pulse_q);
            if (miss)
            begin
                good_q <= 3'h0;
                lock_q <= 1'b0;
            end
            else if (coincide && good_q != lock_need)
                good_q <= 3'(good_q + 3'h1);
            if (good_q == lock_need)
                lock_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins out
    logic mux_d;
    logic cp_drive;
    assign mux_d = (mux_sel == ssp_pkg::MUX_LOCK) ? lock_q :
                   (mux_sel == ssp_pkg::MUX_FBK_DIV) ? fbk_pulse_q :
                   (mux_sel == ssp_pkg::MUX_REF_DIV) ? ref_pulse_q :
                   1'b0;
    assign cp_drive = powered && !func_latch_q[ssp_pkg::CP_TRI_BIT]
                      && (up_q || dn_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            charge_pump_output <= 1'b0;
            charge_pump_output_oe_n <= 1'b1;
            observe_mux_output <= 1'b0;
            ref_path_switch_a <= 1'b0;
            ref_path_switch_b <= 1'b0;
            ref_idle_switch <= 1'b1;
        end
        else
        begin
            charge_pump_output <= up_q ^ func_latch_q[ssp_pkg::CP_POL_BIT];
            charge_pump_output_oe_n <= !cp_drive;
            observe_mux_output <= mux_d;
            ref_path_switch_a <= powered;
            ref_path_switch_b <= powered;
            ref_idle_switch <= !powered;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wr_go;
    logic wr_ok;
    logic [31:0] status;
    logic [31:0] rd_word;
    logic rd_ok;

    assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
    assign wr_ok = awaddr_q == ssp_pkg::A_CTRL;
    assign status = {26'h0000000, shift_q[1:0], lock_q, powered, ce_lvl,
                     !charge_pump_output_oe_n};
    assign rd_ok = s_axi_araddr == ssp_pkg::A_STATUS
                   || s_axi_araddr == ssp_pkg::A_REF
                   || s_axi_araddr == ssp_pkg::A_FBK
                   || s_axi_araddr == ssp_pkg::A_FUNC
                   || s_axi_araddr == ssp_pkg::A_INIT
                   || s_axi_araddr == ssp_pkg::A_SHIFT
                   || s_axi_araddr == ssp_pkg::A_CTRL;
    assign rd_word =
        (s_axi_araddr == ssp_pkg::A_STATUS) ? status :
        (s_axi_araddr == ssp_pkg::A_REF) ? {8'h00, ref_latch_q} :
        (s_axi_araddr == ssp_pkg::A_FBK) ? {8'h00, fbk_latch_q} :
        (s_axi_araddr == ssp_pkg::A_FUNC) ? {8'h00, func_latch_q} :
        (s_axi_araddr == ssp_pkg::A_INIT) ? {8'h00, init_latch_q} :
        (s_axi_araddr == ssp_pkg::A_SHIFT) ? {8'h00, shift_q} :
        (s_axi_araddr == ssp_pkg::A_CTRL) ? {31'h00000000, ctrl_pd_q} :
        32'h00000000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ssp_pkg::RESP_OK;
            ctrl_pd_q <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (wr_go)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? ssp_pkg::RESP_OK
                                     : ssp_pkg::RESP_SLVERR;
                if (wr_ok && s_axi_wstrb[0])
                    ctrl_pd_q <= wdata_q[0];
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ssp_pkg::RESP_OK;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? ssp_pkg::RESP_OK
                                     : ssp_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // ssp_top

/* File: ssp_top_chk.sv */
// ssp_top_chk: port-level assertions for ssp_top
// assumes: bound to ssp_top, single aclk domain
`timescale 1ns/100ps
module ssp_top_chk
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_enable,
    input wire logic charge_pump_output_oe_n,
    input wire logic ref_path_switch_a,
    input wire logic ref_path_switch_b,
    input wire logic ref_idle_switch,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // power gating
    property p_ce_low_tri;
        !chip_enable [*8] |-> charge_pump_output_oe_n;
    endproperty
    a_ce_low_tri: assert property (p_ce_low_tri)
        else $error("pump driven with chip enable low");
    property p_ce_low_idle;
        !chip_enable [*8] |-> ref_idle_switch && !ref_path_switch_a;
    endproperty
    a_ce_low_idle: assert property (p_ce_low_idle)
        else $error("reference path closed with chip enable low");
    property p_idle_tri;
        ref_idle_switch [*2] |-> charge_pump_output_oe_n;
    endproperty
    a_idle_tri: assert property (p_idle_tri)
        else $error("pump driven while powered down");
    property p_switch_excl;
        ref_path_switch_a == ref_path_switch_b &&
            ref_idle_switch != ref_path_switch_a;
    endproperty
    a_switch_excl: assert property (p_switch_excl)
        else $error("reference switches inconsistent");
    property p_power_needs_ce;
        $rose(ref_path_switch_a) |-> chip_enable;
    endproperty
    a_power_needs_ce: assert property (p_power_needs_ce)
        else $error("powered up with chip enable low");

    ////////////////////////////////////////////////////////////////////////
    // register bus
    property p_write_answer;
        s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response missing");
    property p_read_answer;
        s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read data missing");
    property p_rvalid_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rvalid_once: assert property (p_rvalid_once)
        else $error("read answered twice");
    property p_b_blocks;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_blocks: assert property (p_b_blocks)
        else $error("write taken before response done");
endmodule // ssp_top_chk

bind ssp_top ssp_top_chk i_ssp_top_chk (.aclk(aclk), .aresetn(aresetn),
    .chip_enable(chip_enable),
    .charge_pump_output_oe_n(charge_pump_output_oe_n),
    .ref_path_switch_a(ref_path_switch_a),
    .ref_path_switch_b(ref_path_switch_b),
    .ref_idle_switch(ref_idle_switch), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

/* File: ssp_host.sv */
// ssp_host: controller model driving the three load pins
// assumes: serial clock 400 ns period, idle low between frames
`timescale 1ns/100ps
module ssp_host
(
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    initial
    begin
        serial_clk = 1'h0;
        serial_data = 1'h0;
        load_strobe = 1'h0;
    end

    // off-grid start keeps link phase unrelated to aclk
    task automatic send(input logic [23:0] w, input logic strobe);
        #7;
        for (int i = 23; i >= 0; i--)
        begin
            serial_data = w[i];
            #200 serial_clk = 1'h1;
            #200 serial_clk = 1'h0;
        end
        serial_data = ~serial_data;
        if (strobe)
        begin
            #200 load_strobe = 1'h1;
            #400 load_strobe = 1'h0;
        end
        #400;
    endtask
endmodule // ssp_host

/* File: tb_top.sv */
// tb_top: register-bus and pin tests of ssp_top
// assumes: ssp_host drives the load pins, bench owns all others
`timescale 1ns/100ps
module tb_top;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic chip_enable = 1'h1;
    logic reference_input = 1'h0;
    logic rf_feedback_input = 1'h0;
    logic sel_ref = 1'h0;
    logic serial_clk, serial_data, load_strobe;
    logic cp, cp_oe_n, mux_out, sw_a, sw_b, sw_idle;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, data;
    logic [23:0] exp_l [4];
    logic [23:0] ws [4];
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    wire logic pin_sel = sel_ref ? reference_input : rf_feedback_input;

    always #25 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////
    // rf and reference pins, watchdog
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        rf_feedback_input <= (cyc % 10) < 5;
        reference_input <= (cyc % 12) < 6;
        if (cyc == 40000)
        begin
            err_count++;
            complete_run();
        end
    end

    ssp_host i_ssp_host (.serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe));

    ssp_top i_ssp_top (.aclk(aclk), .aresetn(aresetn),
        .serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe), .chip_enable(chip_enable),
        .reference_input(reference_input),
        .rf_feedback_input(rf_feedback_input), .charge_pump_output(cp),
        .charge_pump_output_oe_n(cp_oe_n), .observe_mux_output(mux_out),
        .ref_path_switch_a(sw_a), .ref_path_switch_b(sw_b),
        .ref_idle_switch(sw_idle), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    ////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a,
        input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        data = rdata;
        resp = rresp;
        rready <= 1'h0;
        chk(n, e, data);
        chk({n, " resp"}, 32'(r), 32'(resp));
    endtask

    task automatic latches();
        for (int i = 0; i < 4; i++)
            rd_chk("latch", 8'(ssp_pkg::A_REF + 4 * i), 32'(exp_l[i]),
                ssp_pkg::RESP_OK);
    endtask

    task automatic pwr(input logic on);
        repeat (10) @(posedge aclk);
        chk("path_a", 32'(on), 32'(sw_a));
        chk("path_b", 32'(on), 32'(sw_b));
        chk("idle", 32'(!on), 32'(sw_idle));
        if (!on) chk("oe_n", 32'h1, 32'(cp_oe_n));
        if (!on) chk("cp", 32'h0, 32'(cp));
    endtask

    // pin rises between the 2nd and 3rd mux rises
    task automatic meas(input int n_exp);
        int s;
        int n;
        logic pm;
        logic pp;
        s = 0;
        n = 0;
        pm = mux_out;
        pp = pin_sel;
        while (s < 3)
        begin
            @(posedge aclk);
            if (s == 2 && pin_sel === 1'h1 && pp === 1'h0) n++;
            if (mux_out === 1'h1 && pm === 1'h0) s++;
            pm = mux_out;
            pp = pin_sel;
        end
        chk("divide", 32'(n_exp), 32'(n));
    endtask

    function automatic logic [23:0] fw(input logic [2:0] m,
        input logic [1:0] p, input logic pd, input logic [1:0] sel);
        fw = (24'(p) << ssp_pkg::PRESC_LSB) | (24'(m) << ssp_pkg::MUX_LSB)
            | (24'(pd) << ssp_pkg::PWRDN_BIT) | 24'(sel);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sequence
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (8) @(posedge aclk);
        for (int i = 0; i < 4; i++) exp_l[i] = ssp_pkg::LATCH_RST;
        latches();
        pwr(1'h1);
        ws[0] = (24'h5 << ssp_pkg::REF_CNT_LSB) | 24'(ssp_pkg::SEL_REF);
        ws[1] = (24'h3 << ssp_pkg::MAIN_LSB) | 24'h4 | 24'h1;
        ws[2] = fw(ssp_pkg::MUX_FBK_DIV, 2'h0, 1'h0, ssp_pkg::SEL_FUNC);
        ws[3] = fw(ssp_pkg::MUX_REF_DIV, 2'h0, 1'h0, ssp_pkg::SEL_INIT);
        for (int i = 0; i < 4; i++)
        begin
            i_ssp_host.send(ws[i], 1'h1);
            exp_l[i] = ws[i];
            if (i == 3) exp_l[2] = ws[i];
            rd_chk("shift", ssp_pkg::A_SHIFT, 32'(ws[i]), 2'h0);
            latches();
        end
        i_ssp_host.send(24'hA5A5A6, 1'h0);
        rd_chk("shift", ssp_pkg::A_SHIFT, 32'hA5A5A6, 2'h0);
        latches();
        sel_ref = 1'h1;
        meas(5);
        sel_ref = 1'h0;
        for (int p = 0; p < 4; p++)
        begin
            i_ssp_host.send(fw(ssp_pkg::MUX_FBK_DIV, 2'(p), 1'h0,
                ssp_pkg::SEL_FUNC), 1'h1);
            meas(3 * (8 << p) + 1);
        end
        chip_enable <= 1'h0;
        pwr(1'h0);
        chip_enable <= 1'h1;
        pwr(1'h1);
        axi_wr(ssp_pkg::A_CTRL, 32'h1);
        pwr(1'h0);
        rd_chk("ctrl", ssp_pkg::A_CTRL, 32'h1, ssp_pkg::RESP_OK);
        axi_wr(ssp_pkg::A_CTRL, 32'h0);
        pwr(1'h1);
        i_ssp_host.send(fw(3'h0, 2'h0, 1'h1, ssp_pkg::SEL_FUNC), 1'h1);
        pwr(1'h0);
        chip_enable <= 1'h0;
        pwr(1'h0);
        chip_enable <= 1'h1;
        pwr(1'h0);
        rd_chk("status", ssp_pkg::A_STATUS, 32'h22, ssp_pkg::RESP_OK);
        i_ssp_host.send(fw(3'h0, 2'h0, 1'h0, ssp_pkg::SEL_FUNC), 1'h1);
        pwr(1'h1);
        rd_chk("unmapped", 8'h1C, 32'h0, ssp_pkg::RESP_SLVERR);
        axi_wr(ssp_pkg::A_SHIFT, 32'h0);
        chk("ro resp", 32'(ssp_pkg::RESP_SLVERR), 32'(resp));
        rd_chk("shift", ssp_pkg::A_SHIFT, 32'h2, ssp_pkg::RESP_OK);
        complete_run();
    end
endmodule // tb_top
